/* logic/asq_map.vh */
// Register map and timing constants of the converter sequencer
// Function
// - Stop-on-first-irq halts sequence, clears auto-sample
// - Stop cleared: keep converting, results overwrite
// - Auto-sample restarts sampling, sets sample-enable
// - Manual trigger: writing zero starts conversion
// - Nonzero trigger: hardware ends sampling
// - Sample-enable reads one while acquiring
// - Done flag set on conversion complete
// - Clearing done leaves operation untouched
// - Done cleared when new conversion begins
// - Control bit three reads zero
// - Input select in bits 21:16, low zero
// - Small variant: pins 0-27, ref, temp, open
// - Large variant: pins 0-47, ref, temp, open
// - Disabled: clocks stop, writes ignored; code freezes only timer and sequencer, mux output flops still clock
// - Disable bit one disables, default cleared
`ifndef ASQ_MAP_VH
`define ASQ_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ASQ_OFF_CTRL1       12'h000
`define ASQ_OFF_INSEL       12'h010
`define ASQ_OFF_PMD         12'h020
`define ASQ_OFF_STATUS      12'h030

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASQ_BIT_DONE        0
`define ASQ_BIT_SAMPLE_ENABLE        1
`define ASQ_BIT_AUTO_SAMPLE        2
`define ASQ_BIT_STOP        4
`define ASQ_TRIG_LSB        5
`define ASQ_TRIG_MSB        7
`define ASQ_BIT_ON          15
`define ASQ_SEL_LSB         16
`define ASQ_SEL_MSB         21
`define ASQ_BIT_PMD         0
`define ASQ_BIT_IRQ         0
`define ASQ_BIT_SEQEND      1
`define ASQ_BIT_SAMPLING    2
`define ASQ_BIT_CONVERTING  3

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define ASQ_RST_CTRL1       32'h0000_0000
`define ASQ_RST_INSEL       6'h00
`define ASQ_TRIG_MANUAL     3'h0
`define ASQ_SEL_SMALL_LAST  6'h1B
`define ASQ_SEL_SMALL_REF   6'h1C
`define ASQ_SEL_SMALL_TEMP  6'h1D
`define ASQ_SEL_SMALL_OPEN  6'h1E
`define ASQ_SEL_LARGE_LAST  6'h2F
`define ASQ_SEL_LARGE_REF   6'h30
`define ASQ_SEL_LARGE_TEMP  6'h31
`define ASQ_SEL_LARGE_OPEN  6'h32

// ----------------------------------------
// Timing
// ----------------------------------------
`define ASQ_CLK_MHZ         50
`define ASQ_CONV_NS         240
`define ASQ_CONV_CYCLES     ((`ASQ_CONV_NS * `ASQ_CLK_MHZ + 999) / 1000)
`define ASQ_AUTO_SAMPLE_ENABLE_NS    100
`define ASQ_AUTO_SAMPLE_ENABLE_CYC   ((`ASQ_AUTO_SAMPLE_ENABLE_NS * `ASQ_CLK_MHZ + 999) / 1000)

`endif

/* logic/asq_input_decode.v */
// Positive-input multiplexer decoder for both pin-count variants
`timescale 1ns/100ps
`default_nettype none
`include "asq_map.vh"

module asq_input_decode
(
  input  wire       large_variant,
  input  wire [5:0] positive_input_select,
  output reg  [5:0] analog_pin,
  output reg        pin_valid,
  output reg        internal_reference,
  output reg        temperature_sensor_input,
  output reg        open_input,
  output reg        code_reserved
);

  always @*
  begin
    analog_pin               = positive_input_select;
    pin_valid                = 1'b0;
    internal_reference       = 1'b0;
    temperature_sensor_input = 1'b0;
    open_input               = 1'b0;
    code_reserved            = 1'b0;
    if (large_variant)
    begin
      if (positive_input_select <= `ASQ_SEL_LARGE_LAST)
        pin_valid = 1'b1;
      else if (positive_input_select == `ASQ_SEL_LARGE_REF)
        internal_reference = 1'b1;
      else if (positive_input_select == `ASQ_SEL_LARGE_TEMP)
        temperature_sensor_input = 1'b1;
      else if (positive_input_select == `ASQ_SEL_LARGE_OPEN)
        open_input = 1'b1;
      else
        code_reserved = 1'b1;
    end
    else
    begin
      if (positive_input_select <= `ASQ_SEL_SMALL_LAST)
        pin_valid = 1'b1;
      else if (positive_input_select == `ASQ_SEL_SMALL_REF)
        internal_reference = 1'b1;
      else if (positive_input_select == `ASQ_SEL_SMALL_TEMP)
        temperature_sensor_input = 1'b1;
      else if (positive_input_select == `ASQ_SEL_SMALL_OPEN)
        open_input = 1'b1;
      else
        code_reserved = 1'b1;
    end
    if (!pin_valid)
      analog_pin = 6'h00;
  end

endmodule // asq_input_decode
`default_nettype wire

/* logic/asq_conv_timer.v */
// Conversion-time counter: one pulse when a started conversion ends
`timescale 1ns/100ps
`default_nettype none
`include "asq_map.vh"

module asq_conv_timer
(
  input  wire pclk,
  input  wire presetn,
  input  wire run,
  input  wire start,
  output wire busy,
  output reg  finish
);

  localparam integer CONV_CYCLES = `ASQ_CONV_CYCLES;
  localparam [7:0]   CONV_LAST   = CONV_CYCLES[7:0] - 8'h01;

  reg [7:0] count_reg;
  reg       busy_reg;

  assign busy = busy_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= 8'h00;
      busy_reg  <= 1'b0;
      finish    <= 1'b0;
    end
    else if (run)
    begin
      finish <= 1'b0;
      // A new start restarts the count, dropping any run left from a switch-off
      if (start)
      begin
        busy_reg  <= 1'b1;
        count_reg <= 8'h00;
      end
      else if (busy_reg)
      begin
        if (count_reg == CONV_LAST)
        begin
          busy_reg <= 1'b0;
          finish   <= 1'b1;
        end
        else
          count_reg <= count_reg + 8'h01;
      end
    end
    else
      finish <= 1'b0;
  end

endmodule // asq_conv_timer
`default_nettype wire

/* logic/asq_sequencer.v */
// Sample/convert sequencer with its APB register file
`timescale 1ns/100ps
`default_nettype none
`include "asq_map.vh"

module asq_sequencer
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        large_variant,
  input  wire        trigger_in,
  output reg         sample_hold_acquire,
  output reg         convert_start,
  output reg  [5:0]  mux_analog_pin,
  output reg         mux_pin_valid,
  output reg         mux_internal_reference,
  output reg         mux_temperature_sensor,
  output reg         mux_open_input,
  output reg         converter_irq
);

  // ----------------------------------------
  // State machine codes
  // ----------------------------------------
  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_SAMPLE = 2'h1;
  localparam [1:0] ST_CONV   = 2'h2;

  // Integer first, then cut to the counter width on purpose
  localparam integer AUTO_SAMPLE_ENABLE_CYC  = `ASQ_AUTO_SAMPLE_ENABLE_CYC;
  localparam [7:0]   AUTO_SAMPLE_ENABLE_LAST = AUTO_SAMPLE_ENABLE_CYC[7:0] - 8'h01;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg        module_on_reg;
  reg [2:0]  trig_src_reg;
  reg        stop_on_first_irq_reg;
  reg        auto_sample_reg;
  reg        done_reg;
  reg        halted_reg;
  reg [5:0]  insel_reg;
  reg        module_disable_reg;
  reg [7:0]  sample_enable_cnt_reg;

  wire       conv_busy;
  wire       conv_finish;
  wire [5:0] dec_pin;
  wire       dec_valid;
  wire       dec_ref;
  wire       dec_temp;
  wire       dec_open;

  function hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Disabled module ignores all writes except the disable register itself
  wire wr_access = psel && penable && pwrite;
  wire wr_pmd    = wr_access && hit(paddr, `ASQ_OFF_PMD);
  wire wr_en     = wr_access && !module_disable_reg;
  wire wr_ctrl   = wr_en && hit(paddr, `ASQ_OFF_CTRL1);
  wire wr_insel  = wr_en && hit(paddr, `ASQ_OFF_INSEL);
  wire wr_status = wr_en && hit(paddr, `ASQ_OFF_STATUS);
  wire mapped    = hit(paddr, `ASQ_OFF_CTRL1) || hit(paddr, `ASQ_OFF_INSEL) ||
                   hit(paddr, `ASQ_OFF_PMD) || hit(paddr, `ASQ_OFF_STATUS);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Module clock gate modelled as a run qualifier on the timer and sequencer flops; the mux output flops are not gated
  wire run = module_on_reg && !module_disable_reg;

  // ----------------------------------------
  // Sequencing qualifiers
  // ----------------------------------------
  // Same-cycle ON write counts, so one write can switch on and start sampling
  wire on_next     = wr_ctrl ? pwdata[`ASQ_BIT_ON] : module_on_reg;
  wire sampling    = (state_reg == ST_SAMPLE);
  wire sw_sample_enable_set = wr_ctrl && pwdata[`ASQ_BIT_SAMPLE_ENABLE];
  wire sw_sample_enable_clr = wr_ctrl && !pwdata[`ASQ_BIT_SAMPLE_ENABLE];
  wire manual_trig = (trig_src_reg == `ASQ_TRIG_MANUAL);
  wire auto_sample_ready = (sample_enable_cnt_reg == AUTO_SAMPLE_ENABLE_LAST);
  // Hardware end of sampling: external trigger, or code 7 timed internally
  wire hw_end_sample = !manual_trig &&
                       (trigger_in || (trig_src_reg == 3'h7 && auto_sample_ready));
  // A run cut short by switching off leaves the timer busy; its late finish
  // outside a conversion must not set done or raise the irq
  wire conv_done    = conv_finish && (state_reg == ST_CONV);
  wire sequence_irq = conv_done;

  // ----------------------------------------
  // Sample/convert state machine
  // ----------------------------------------
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (sw_sample_enable_set && !auto_sample_reg)
          state_next = ST_SAMPLE;
        else if (auto_sample_reg && !halted_reg)
          state_next = ST_SAMPLE;
      end
      ST_SAMPLE:
      begin
        if (manual_trig && sw_sample_enable_clr)
          state_next = ST_CONV;
        else if (hw_end_sample)
          state_next = ST_CONV;
      end
      ST_CONV:
      begin
        if (conv_done)
        begin
          if (auto_sample_reg && !stop_on_first_irq_reg)
            state_next = ST_SAMPLE;
          else
            state_next = ST_IDLE;
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
    if (!on_next)
      state_next = ST_IDLE;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg     <= ST_IDLE;
      sample_enable_cnt_reg  <= 8'h00;
      convert_start <= 1'b0;
      halted_reg    <= 1'b0;
    end
    else if (run || !module_on_reg)
    begin
      state_reg     <= state_next;
      convert_start <= (state_reg == ST_SAMPLE) && (state_next == ST_CONV);
      if (state_reg == ST_SAMPLE && !auto_sample_ready)
        sample_enable_cnt_reg <= sample_enable_cnt_reg + 8'h01;
      else if (state_reg != ST_SAMPLE)
        sample_enable_cnt_reg <= 8'h00;
      if (sequence_irq && stop_on_first_irq_reg)
        halted_reg <= 1'b1;
      else if (wr_ctrl && pwdata[`ASQ_BIT_AUTO_SAMPLE])
        halted_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      module_on_reg         <= 1'b0;
      trig_src_reg          <= 3'h0;
      stop_on_first_irq_reg <= 1'b0;
      auto_sample_reg       <= 1'b0;
      done_reg              <= 1'b0;
      insel_reg             <= `ASQ_RST_INSEL;
      module_disable_reg    <= 1'b0;
      converter_irq         <= 1'b0;
    end
    else
    begin
      if (wr_pmd)
        module_disable_reg <= pwdata[`ASQ_BIT_PMD];
      if (wr_ctrl)
      begin
        module_on_reg         <= pwdata[`ASQ_BIT_ON];
        trig_src_reg          <= pwdata[`ASQ_TRIG_MSB:`ASQ_TRIG_LSB];
        stop_on_first_irq_reg <= pwdata[`ASQ_BIT_STOP];
        auto_sample_reg       <= pwdata[`ASQ_BIT_AUTO_SAMPLE];
      end
      if (run && sequence_irq && stop_on_first_irq_reg)
        auto_sample_reg <= 1'b0;
      if (wr_insel)
        insel_reg <= pwdata[`ASQ_SEL_MSB:`ASQ_SEL_LSB];
      // Hardware set beats a simultaneous software clear
      if (run && conv_done)
        done_reg <= 1'b1;
      else if (run && convert_start)
        done_reg <= 1'b0;
      else if (wr_ctrl && !pwdata[`ASQ_BIT_DONE])
        done_reg <= 1'b0;
      if (run && sequence_irq)
        converter_irq <= 1'b1;
      else if (wr_status && pwdata[`ASQ_BIT_IRQ])
        converter_irq <= 1'b0;
    end
  end

  // ----------------------------------------
  // Conversion timer and input decoder
  // ----------------------------------------
  asq_conv_timer u_conv_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .start   (convert_start),
    .busy    (conv_busy),
    .finish  (conv_finish)
  );

  asq_input_decode u_input_decode
  (
    .large_variant            (large_variant),
    .positive_input_select    (insel_reg),
    .analog_pin               (dec_pin),
    .pin_valid                (dec_valid),
    .internal_reference       (dec_ref),
    .temperature_sensor_input (dec_temp),
    .open_input               (dec_open),
    .code_reserved            ()
  );

  // ----------------------------------------
  // Sample/hold and multiplexer outputs
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_hold_acquire    <= 1'b0;
      mux_analog_pin         <= 6'h00;
      mux_pin_valid          <= 1'b0;
      mux_internal_reference <= 1'b0;
      mux_temperature_sensor <= 1'b0;
      mux_open_input         <= 1'b0;
    end
    else
    begin
      sample_hold_acquire    <= (state_next == ST_SAMPLE) && run;
      mux_analog_pin         <= dec_pin;
      mux_pin_valid          <= dec_valid;
      mux_internal_reference <= dec_ref;
      mux_temperature_sensor <= dec_temp;
      mux_open_input         <= dec_open;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Reads of a disabled module return zero except the disable register; their value has no meaning
  always @*
  begin
    prdata = 32'h0000_0000;
    if (psel && !module_disable_reg)
    begin
      if (hit(paddr, `ASQ_OFF_CTRL1))
      begin
        prdata[`ASQ_BIT_ON]                     = module_on_reg;
        prdata[`ASQ_TRIG_MSB:`ASQ_TRIG_LSB]     = trig_src_reg;
        prdata[`ASQ_BIT_STOP]                   = stop_on_first_irq_reg;
        prdata[`ASQ_BIT_AUTO_SAMPLE]                   = auto_sample_reg;
        prdata[`ASQ_BIT_SAMPLE_ENABLE]                   = sampling;
        prdata[`ASQ_BIT_DONE]                   = done_reg;
        // Bit three left at zero
      end
      else if (hit(paddr, `ASQ_OFF_INSEL))
        prdata[`ASQ_SEL_MSB:`ASQ_SEL_LSB] = insel_reg;
      else if (hit(paddr, `ASQ_OFF_STATUS))
      begin
        // Sticky irq, cleared by writing one
        prdata[`ASQ_BIT_IRQ]        = converter_irq;
        prdata[`ASQ_BIT_SEQEND]     = halted_reg;
        prdata[`ASQ_BIT_SAMPLING]   = sampling;
        prdata[`ASQ_BIT_CONVERTING] = conv_busy;
      end
    end
    if (psel && hit(paddr, `ASQ_OFF_PMD))
      prdata[`ASQ_BIT_PMD] = module_disable_reg;
  end

endmodule // asq_sequencer
`default_nettype wire

/* test/asq_frontend_model.sv */
// Sample-and-hold front end model driving the end-of-sample trigger
`timescale 1ns/100ps
`default_nettype none
module asq_frontend_model
#(
  parameter int ACQ_CYC = 3
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sample_hold_acquire,
  output var  logic trigger_in
);
  int n;
  // Trigger is a one-cycle level after a fixed settling time
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      n <= 0;
      trigger_in <= 1'b0;
    end
    else
    begin
      n <= sample_hold_acquire ? n + 1 : 0;
      trigger_in <= sample_hold_acquire && n == ACQ_CYC - 1;
    end
  end
endmodule // asq_frontend_model
`default_nettype wire

/* test/asq_sequencer_chk.sv */
// Port-level assertions for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "asq_map.vh"
module asq_sequencer_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        sample_hold_acquire,
  input wire logic        convert_start,
  input wire logic [5:0]  mux_analog_pin,
  input wire logic        mux_pin_valid,
  input wire logic        mux_internal_reference,
  input wire logic        mux_temperature_sensor,
  input wire logic        mux_open_input,
  input wire logic        converter_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       pmd_reg;
  logic       on_reg;
  logic       auto_reg;
  logic       stop_reg;
  logic [5:0] cyc_reg;
  wire logic acc = psel && penable && pready;
  wire logic rd_ctl = acc && !pwrite && paddr == `ASQ_OFF_CTRL1;
  wire logic wr_ctl = acc && pwrite && paddr == `ASQ_OFF_CTRL1 && !pmd_reg;
  wire logic mapped = paddr == `ASQ_OFF_CTRL1 || paddr == `ASQ_OFF_INSEL
                      || paddr == `ASQ_OFF_PMD || paddr == `ASQ_OFF_STATUS;
  // ----------------------------------------
  // Shadow of software settings
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pmd_reg <= 1'b0;
      on_reg <= 1'b0;
      auto_reg <= 1'b0;
      stop_reg <= 1'b0;
      cyc_reg <= 6'h3F;
    end
    else
    begin
      if (acc && pwrite && paddr == `ASQ_OFF_PMD)
        pmd_reg <= pwdata[0];
      if (wr_ctl)
      begin
        on_reg <= pwdata[15];
        auto_reg <= pwdata[2];
        stop_reg <= pwdata[4];
      end
      if (convert_start)
        cyc_reg <= 6'h00;
      else if (cyc_reg != 6'h3F)
        cyc_reg <= cyc_reg + 6'h01;
    end
  end
  sequence s_no_start;
    (!convert_start)[*8];
  endsequence
  sequence s_no_acquire;
    (!sample_hold_acquire)[*8];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_err_unmapped: assert property (psel && penable |-> pready && pslverr == !mapped)
    else $error("pslverr does not match address decode");
  chk_ctrl_bit3: assert property (rd_ctl |-> !prdata[3])
    else $error("control bit three read as one");
  chk_insel_zero: assert property (acc && !pwrite && paddr == `ASQ_OFF_INSEL
    |-> prdata[15:0] == 16'h0000 && prdata[31:22] == 10'h000)
    else $error("input select unused bits not zero");
  chk_mux_onehot: assert property ($onehot0({mux_pin_valid, mux_internal_reference,
    mux_temperature_sensor, mux_open_input}) && (mux_pin_valid || mux_analog_pin == 6'h00))
    else $error("mux select outputs inconsistent");
  chk_start_gap: assert property (convert_start |=> s_no_start)
    else $error("conversion restarted too soon");
  chk_irq_timing: assert property ($rose(converter_irq) |-> cyc_reg inside {[10:15]})
    else $error("irq not tied to conversion end");
  chk_sample_start: assert property (wr_ctl && pwdata[15] && pwdata[1] && !pwdata[2]
    && !sample_hold_acquire |-> ##[1:3] sample_hold_acquire)
    else $error("sampling did not start");
  chk_manual_conv: assert property (wr_ctl && pwdata[15] && !pwdata[1]
    && pwdata[7:5] == 3'h0 && sample_hold_acquire |-> ##[1:3] convert_start)
    else $error("manual end of sampling did not convert");
  chk_auto_again: assert property (convert_start && on_reg && auto_reg && !stop_reg
    |-> ##[12:20] (sample_hold_acquire || !auto_reg))
    else $error("auto sampling did not restart");
  chk_stop_first: assert property (convert_start && auto_reg && stop_reg
    |-> ##12 s_no_acquire)
    else $error("sequence kept sampling after first irq");
endmodule // asq_sequencer_chk
`default_nettype wire

/* test/tb.sv */
// Register-level testbench of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "asq_map.vh"
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        large_variant = 1'b0;
  logic [31:0] rd;
  logic        err;
  logic        pready, pslverr, trigger_in, sample_hold_acquire, convert_start;
  logic        mux_pin_valid, mux_internal_reference, mux_temperature_sensor;
  logic        mux_open_input, converter_irq;
  logic [31:0] prdata;
  logic [5:0]  mux_analog_pin;
  int          n_mismatch = 0;
  int          checked = 0;
  asq_sequencer asq_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .large_variant(large_variant),
    .trigger_in(trigger_in), .sample_hold_acquire(sample_hold_acquire),
    .convert_start(convert_start), .mux_analog_pin(mux_analog_pin),
    .mux_pin_valid(mux_pin_valid), .mux_internal_reference(mux_internal_reference),
    .mux_temperature_sensor(mux_temperature_sensor), .mux_open_input(mux_open_input),
    .converter_irq(converter_irq));
  asq_frontend_model #(.ACQ_CYC(8)) asq_frontend_model_inst (.pclk(pclk),
    .presetn(presetn), .sample_hold_acquire(sample_hold_acquire), .trigger_in(trigger_in));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready", n < 16, 1);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check("register read", rd, exp);
  endtask
  // Polls one event: 0 for conversion start, 1 for irq
  task automatic wait_ev(input int which);
    int n;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((which == 0 ? convert_start : converter_irq) !== 1'b1 && n < 200);
    check("event wait", n < 200, 1);
  endtask
  function automatic logic [9:0] mux_exp(input logic lg, input logic [5:0] c);
    logic [5:0] last;
    last = lg ? 6'h2F : 6'h1B;
    if (c <= last)
      return {c, 4'b1000};
    if (c == last + 6'h01)
      return 10'h004;
    if (c == last + 6'h02)
      return 10'h002;
    if (c == last + 6'h03)
      return 10'h001;
    return 10'h000;
  endfunction
  task automatic conclude;
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude;
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`ASQ_OFF_CTRL1, 32'h0000_0000);
    rdchk(`ASQ_OFF_INSEL, 32'h0000_0000);
    rdchk(`ASQ_OFF_PMD, 32'h0000_0000);
    xfer(1'b0, 12'h040, 32'h0000_0000);
    check("unmapped error", err, 1);
    xfer(1'b1, `ASQ_OFF_CTRL1, 32'h0000_0008);
    rdchk(`ASQ_OFF_CTRL1, 32'h0000_0000);
    xfer(1'b1, `ASQ_OFF_INSEL, 32'hFFFF_FFFF);
    rdchk(`ASQ_OFF_INSEL, 32'h003F_0000);
    for (int lg = 0; lg < 2; lg++)
      for (int c = 0; c < 64; c++)
      begin
        large_variant <= lg[0];
        xfer(1'b1, `ASQ_OFF_INSEL, {10'h000, c[5:0], 16'h0000});
        repeat (3) @(posedge pclk);
        check("mux", {mux_analog_pin, mux_pin_valid, mux_internal_reference,
          mux_temperature_sensor, mux_open_input}, mux_exp(lg[0], c[5:0]));
      end
    xfer(1'b1, `ASQ_OFF_CTRL1, 32'h0000_8002);
    repeat (3) @(posedge pclk);
    rdchk(`ASQ_OFF_CTRL1, 32'h0000_8002);
    rdchk(`ASQ_OFF_STATUS, 32'h0000_0004);
    xfer(1'b1, `ASQ_OFF_CTRL1, 32'h0000_8000);
    wait_ev(0);
    xfer(1'b1, `ASQ_OFF_CTRL1, 32'h0000_8000);
    rdchk(`ASQ_OFF_CTRL1, 32'h0000_8000);
    wait_ev(1);
    rdchk(`ASQ_OFF_CTRL1, 32'h0000_8001);
    rdchk(`ASQ_OFF_STATUS, 32'h0000_0001);
    xfer(1'b1, `ASQ_OFF_CTRL1, 32'h0000_8000);
    rdchk(`ASQ_OFF_CTRL1, 32'h0000_8000);
    xfer(1'b1, `ASQ_OFF_STATUS, 32'h0000_0001);
    for (int t = 1; t < 8; t++)
    begin
      xfer(1'b1, `ASQ_OFF_CTRL1, 32'h0000_8002 | (t << 5));
      wait_ev(0);
      rdchk(`ASQ_OFF_CTRL1, 32'h0000_8000 | (t << 5));
      rdchk(`ASQ_OFF_STATUS, 32'h0000_0008);
      wait_ev(1);
      rdchk(`ASQ_OFF_CTRL1, 32'h0000_8001 | (t << 5));
      xfer(1'b1, `ASQ_OFF_STATUS, 32'h0000_0001);
    end
    xfer(1'b1, `ASQ_OFF_CTRL1, 32'h0000_80F6);
    wait_ev(1);
    repeat (30) @(posedge pclk);
    rdchk(`ASQ_OFF_CTRL1, 32'h0000_80F1);
    rdchk(`ASQ_OFF_STATUS, 32'h0000_0003);
    xfer(1'b1, `ASQ_OFF_STATUS, 32'h0000_0001);
    xfer(1'b1, `ASQ_OFF_CTRL1, 32'h0000_80E6);
    wait_ev(1);
    wait_ev(0);
    rdchk(`ASQ_OFF_CTRL1, 32'h0000_80E4);
    wait_ev(0);
    xfer(1'b1, `ASQ_OFF_CTRL1, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    xfer(1'b1, `ASQ_OFF_STATUS, 32'h0000_0001);
    xfer(1'b1, `ASQ_OFF_PMD, 32'h0000_0001);
    xfer(1'b1, `ASQ_OFF_CTRL1, 32'h0000_8002);
    repeat (5) @(posedge pclk);
    check("acquire while disabled", sample_hold_acquire, 0);
    rdchk(`ASQ_OFF_PMD, 32'h0000_0001);
    xfer(1'b1, `ASQ_OFF_PMD, 32'h0000_0000);
    rdchk(`ASQ_OFF_CTRL1, 32'h0000_0000);
    conclude;
  end
endmodule // tb
bind asq_sequencer asq_sequencer_chk asq_sequencer_chk_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .sample_hold_acquire(sample_hold_acquire), .convert_start(convert_start),
  .mux_analog_pin(mux_analog_pin), .mux_pin_valid(mux_pin_valid),
  .mux_internal_reference(mux_internal_reference),
  .mux_temperature_sensor(mux_temperature_sensor), .mux_open_input(mux_open_input),
  .converter_irq(converter_irq));
`default_nettype wire
